// [eeprom_regs.svh]
// Register offsets, field positions, reset values and timing figures of the data EEPROM access block.
`ifndef EEPROM_ACCESS_REGS_SVH
`define EEPROM_ACCESS_REGS_SVH

// =====================================================================
// Special function register offsets
// =====================================================================
`define EE_DATA_OFS 8'h08
`define EE_ADDR_OFS 8'h09
`define EE_CTRL_OFS 8'h88
`define EE_AUX_OFS 8'h89

// =====================================================================
// Control register field positions
// =====================================================================
`define EE_RD_BIT 0
`define EE_WR_BIT 1
`define EE_PERMIT_BIT 2
`define EE_ABORT_BIT 3
`define EE_DONE_BIT 4

// =====================================================================
// Values
// =====================================================================
`define EE_BYTE_ZERO 8'h00
`define EE_BYTE_ERASED 8'hFF
`define EE_UPPER_ZERO 2'b00
`define EE_CTRL_UNUSED 3'h0

// =====================================================================
// Timing
// =====================================================================
`define EE_CLK_PERIOD_NS 10
`define EE_ERASE_TIME_US 2000
`define EE_PROG_TIME_US 2000

`endif

// [eeprom_pkg.sv]
// Types and shared decode helpers of the data EEPROM access block.
`include "eeprom_regs.svh"

package eeprom_pkg;

  // ===================================================================
  // Self-timed write sequencer states
  // ===================================================================
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROGRAM = 2'b10
  } wr_state_e;

  // True when the two upper address bits select the implemented space.
  function automatic logic addr_in_space(input logic [7:0] addr);
    return addr[7:6] == `EE_UPPER_ZERO;
  endfunction

endpackage

// [eeprom_cell_array.sv]
// Flip-flop storage of the data EEPROM with per-byte erase and program.
`timescale 1ns/10ps
`default_nettype none

module eeprom_cell_array
  import eeprom_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic erase_in,
  input wire logic program_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  // =====================================================================
  // Storage
  // =====================================================================
  // One byte per location; content after power-up is the erased value.
  logic [7:0] cell_q [DEPTH];

  // Programming can only clear bits, so a program without an erase just ANDs.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        cell_q[i] <= `EE_BYTE_ERASED;
      end
    end
    else if (erase_in && program_in)
    begin
      // Combined erase and program loads the byte outright.
      cell_q[addr_in] <= data_in;
    end
    else if (erase_in)
    begin
      cell_q[addr_in] <= `EE_BYTE_ERASED;
    end
    else if (program_in)
    begin
      cell_q[addr_in] <= cell_q[addr_in] & data_in;
    end
  end

  // Asynchronous read port; the user registers the result.
  assign rd_data_out = cell_q[rd_addr_in];

endmodule // eeprom_cell_array

`default_nettype wire

// [eeprom_access_ctrl.sv]
// Data EEPROM access control: indirect registers, self-timed byte write and programmer gate.
//
// Summary of operation
// [RULE1] Core reads and writes EEPROM during normal operation.
// [RULE2] Array reached only through address, data, control registers.
// [RULE3] Data register holds the byte read or written.
// [RULE4] Sixty-four bytes, addresses zero to 3Fh.
// [RULE5] Eight-bit address; upper two bits must be zero.
// [RULE6] Write erases the byte first, then programs.
// [RULE7] Internal timer governs write; hardware signals completion.
// [RULE8] Protected: core keeps access, programmer is refused.
// [RULE9] Done flag bit 4 set on finish, software clears.
// [RULE10] Abort flag bit 3 set when reset cuts write.
// [RULE11] Bit 1 starts write; hardware clears; zero ignored.
// [RULE12] Bit 0 fetches byte in one cycle, self-clearing.
// [RULE13] ROM variant: config bit 7 zero protects data.
// [RULE14] Write start ignored unless permit bit 2 set.
// [RULE15] Control bits 7 to 5 read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

module eeprom_access_ctrl
  import eeprom_pkg::*;
#(
  parameter bit ROM_VARIANT = 1'b0,
  parameter int CNT_W = 24,
  parameter int ERASE_CYCLES = (`EE_ERASE_TIME_US * 1000) / `EE_CLK_PERIOD_NS,
  parameter int PROG_CYCLES = (`EE_PROG_TIME_US * 1000) / `EE_CLK_PERIOD_NS
)
(
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic MASTER_CLEAR_RESET_IN,
  input wire logic WATCHDOG_TIMER_RESET_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  input wire logic CODE_PROTECT_IN,
  input wire logic DATA_PROTECT_BIT_IN,
  input wire logic PROG_MODE_IN,
  input wire logic [5:0] PROG_ADDR_IN,
  input wire logic PROG_RD_IN,
  input wire logic PROG_WR_IN,
  input wire logic [7:0] PROG_WDATA_IN,
  output logic [7:0] PROG_RDATA_OUT,
  output logic PROG_DENIED_OUT,
  output logic WRITE_BUSY_OUT
);

  // =====================================================================
  // Declarations
  // =====================================================================
  wr_state_e state_q; // Write sequencer state.
  logic [CNT_W-1:0] cnt_q; // Phase timer, counts down to zero.
  logic [7:0] eeprom_address_reg_q; // Software address register.
  logic [7:0] eeprom_data_reg_q; // Software data register.
  logic [7:0] wr_addr_q; // Address latched at write start.
  logic [7:0] wr_data_q; // Data latched at write start.
  logic rd_q; // Read-start bit.
  logic wr_q; // Write-start bit, doubles as busy.
  logic write_permit_q; // Write-permit bit.
  logic write_abort_flag_q; // Sticky abort flag.
  logic write_done_flag_q; // Sticky completion flag.
  logic core_rst; // Master-clear or watchdog reset in normal operation.
  logic ctrl_wr; // Software write to the control register.
  logic start_wr; // A permitted write request.
  logic erase_end; // Last cycle of the erase phase.
  logic write_end; // Last cycle of the program phase.
  logic protected_data; // Programmer must be kept out.
  logic prog_ok; // Programmer access allowed this cycle.
  logic arr_erase; // Array erase strobe.
  logic arr_program; // Array program strobe.
  logic [5:0] arr_addr; // Array write address.
  logic [7:0] arr_wdata; // Array write data.
  logic [5:0] arr_raddr; // Array read address.
  logic [7:0] arr_rdata; // Array read data.
  logic [7:0] ctrl_view; // Control register as software sees it.

  // =====================================================================
  // Decode
  // =====================================================================
  // The two reset sources act identically on this block.
  assign core_rst = MASTER_CLEAR_RESET_IN | WATCHDOG_TIMER_RESET_IN;
  assign ctrl_wr = SFR_WR_IN && (SFR_ADDR_IN == `EE_CTRL_OFS);
  // A new write needs the permit bit in the same written value and an idle sequencer.
  assign start_wr = ctrl_wr && SFR_WDATA_IN[`EE_WR_BIT] && SFR_WDATA_IN[`EE_PERMIT_BIT] && !wr_q; // see [RULE14]
  assign erase_end = (state_q == ST_ERASE) && (cnt_q == '0);
  assign write_end = (state_q == ST_PROGRAM) && (cnt_q == '0); // see [RULE7]
  // ROM parts use the data-protect bit (zero protects), flash parts the code-protect strap.
  assign protected_data = ROM_VARIANT ? !DATA_PROTECT_BIT_IN : CODE_PROTECT_IN; // see [RULE13]
  // The programmer is also held off while a core write is in flight.
  assign prog_ok = PROG_MODE_IN && !protected_data && !wr_q; // see [RULE8]
  assign ctrl_view = {`EE_CTRL_UNUSED, write_done_flag_q, write_abort_flag_q, write_permit_q, wr_q, rd_q}; // see [RULE15]

  // =====================================================================
  // Array access steering
  // =====================================================================
  // Core writes go erase then program; out-of-space writes touch nothing.
  always_comb
  begin
    arr_erase = 1'b0;
    arr_program = 1'b0;
    arr_addr = wr_addr_q[5:0];
    arr_wdata = wr_data_q;
    if (wr_q)
    begin
      arr_erase = erase_end && addr_in_space(wr_addr_q); // see [RULE6] [RULE5]
      arr_program = write_end && addr_in_space(wr_addr_q); // see [RULE6] [RULE4]
    end
    else if (prog_ok && PROG_WR_IN)
    begin
      // The programmer loads a byte in one cycle.
      arr_erase = 1'b1;
      arr_program = 1'b1;
      arr_addr = PROG_ADDR_IN;
      arr_wdata = PROG_WDATA_IN;
    end
  end

  // A due core read owns the read port, so a programmer address never leaks into the data register.
  assign arr_raddr = (prog_ok && !rd_q) ? PROG_ADDR_IN : eeprom_address_reg_q[5:0]; // see [RULE8]

  eeprom_cell_array #(
    .DEPTH(64),
    .AW(6)
  ) u_cells (
    .clk_in(CORE_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .erase_in(arr_erase),
    .program_in(arr_program),
    .addr_in(arr_addr),
    .data_in(arr_wdata),
    .rd_addr_in(arr_raddr),
    .rd_data_out(arr_rdata)
  );

  // =====================================================================
  // Write sequencer and timer
  // =====================================================================
  // Each phase runs for its own cycle count; a core reset drops the write at once.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end
    else if (core_rst)
    begin
      state_q <= ST_IDLE; // see [RULE10]
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_wr)
          begin
            state_q <= ST_ERASE; // see [RULE11]
            cnt_q <= CNT_W'(ERASE_CYCLES - 1);
          end
        end
        ST_ERASE:
        begin
          if (erase_end)
          begin
            state_q <= ST_PROGRAM; // see [RULE6]
            cnt_q <= CNT_W'(PROG_CYCLES - 1);
          end
          else
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_PROGRAM:
        begin
          if (write_end)
          begin
            state_q <= ST_IDLE; // see [RULE7]
          end
          else
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default:
        begin
          // The spare code returns to idle rather than lock the block.
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Address and data are frozen at the start so software may reuse the registers.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      wr_addr_q <= `EE_BYTE_ZERO;
      wr_data_q <= `EE_BYTE_ZERO;
    end
    else if (start_wr)
    begin
      wr_addr_q <= eeprom_address_reg_q;
      wr_data_q <= eeprom_data_reg_q; // see [RULE3]
    end
  end

  // =====================================================================
  // Control register bits
  // =====================================================================
  // Start bits are settable only: a written zero leaves them alone.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      write_permit_q <= 1'b0;
    end
    else if (core_rst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      write_permit_q <= 1'b0;
    end
    else
    begin
      if (start_wr)
      begin
        wr_q <= 1'b1; // see [RULE11] [RULE14]
      end
      else if (write_end)
      begin
        wr_q <= 1'b0; // see [RULE11]
      end
      // A read is not started while a write owns the array.
      if (rd_q)
      begin
        rd_q <= 1'b0; // see [RULE12]
      end
      else if (ctrl_wr && SFR_WDATA_IN[`EE_RD_BIT] && !wr_q)
      begin
        rd_q <= 1'b1; // see [RULE12]
      end
      if (ctrl_wr)
      begin
        write_permit_q <= SFR_WDATA_IN[`EE_PERMIT_BIT];
      end
    end
  end

  // Flags: a hardware event in the same cycle as a software clear wins.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      write_done_flag_q <= 1'b0;
      write_abort_flag_q <= 1'b0;
    end
    else if (core_rst)
    begin
      write_done_flag_q <= 1'b0;
      write_abort_flag_q <= write_abort_flag_q | wr_q; // see [RULE10]
    end
    else if (write_end)
    begin
      write_done_flag_q <= 1'b1; // see [RULE9]
      write_abort_flag_q <= 1'b0; // see [RULE10]
    end
    else if (ctrl_wr)
    begin
      write_done_flag_q <= SFR_WDATA_IN[`EE_DONE_BIT]; // see [RULE9]
      write_abort_flag_q <= SFR_WDATA_IN[`EE_ABORT_BIT];
    end
  end

  // =====================================================================
  // Address and data registers
  // =====================================================================
  // These keep their value over a core reset, like the array itself.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      eeprom_address_reg_q <= `EE_BYTE_ZERO;
    end
    else if (SFR_WR_IN && (SFR_ADDR_IN == `EE_ADDR_OFS))
    begin
      eeprom_address_reg_q <= SFR_WDATA_IN; // see [RULE5]
    end
  end

  // A completing read outranks a software write in the same cycle.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      eeprom_data_reg_q <= `EE_BYTE_ZERO;
    end
    else if (rd_q)
    begin
      // Outside the implemented space nothing answers, so zero is returned.
      eeprom_data_reg_q <= addr_in_space(eeprom_address_reg_q) ? arr_rdata : `EE_BYTE_ZERO; // see [RULE12] [RULE5]
    end
    else if (SFR_WR_IN && (SFR_ADDR_IN == `EE_DATA_OFS))
    begin
      eeprom_data_reg_q <= SFR_WDATA_IN; // see [RULE3]
    end
  end

  // =====================================================================
  // Read-back and outputs
  // =====================================================================
  // Read data is registered, valid the cycle after the address; the auxiliary register reads zero.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      SFR_RDATA_OUT <= `EE_BYTE_ZERO;
    end
    else
    begin
      unique case (SFR_ADDR_IN)
        `EE_DATA_OFS: SFR_RDATA_OUT <= eeprom_data_reg_q; // see [RULE2]
        `EE_ADDR_OFS: SFR_RDATA_OUT <= eeprom_address_reg_q;
        `EE_CTRL_OFS: SFR_RDATA_OUT <= ctrl_view; // see [RULE15]
        default: SFR_RDATA_OUT <= `EE_BYTE_ZERO;
      endcase
    end
  end

  // The programmer sees zero and a denial flag whenever data is protected.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      PROG_RDATA_OUT <= `EE_BYTE_ZERO;
      PROG_DENIED_OUT <= 1'b0;
      WRITE_BUSY_OUT <= 1'b0;
    end
    else
    begin
      PROG_RDATA_OUT <= (prog_ok && PROG_RD_IN && !rd_q) ? arr_rdata : `EE_BYTE_ZERO; // see [RULE8]
      PROG_DENIED_OUT <= PROG_MODE_IN && protected_data; // see [RULE8]
      WRITE_BUSY_OUT <= wr_q | start_wr; // see [RULE1]
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence s_erase_end;
    (state_q == ST_ERASE) && (cnt_q == '0) && !core_rst;
  endsequence

  sequence s_write_end;
    (state_q == ST_PROGRAM) && (cnt_q == '0) && !core_rst;
  endsequence

  chk_permit_needed: assert property (ctrl_wr && SFR_WDATA_IN[`EE_WR_BIT] && !SFR_WDATA_IN[`EE_PERMIT_BIT] && !wr_q
    |=> !wr_q) else $error("write started without permit"); // see [RULE14]
  chk_read_one_cycle: assert property (rd_q && !core_rst |=> !rd_q
    && eeprom_data_reg_q == (addr_in_space($past(eeprom_address_reg_q)) ? $past(arr_rdata) : `EE_BYTE_ZERO))
    else $error("read did not complete in one cycle"); // see [RULE12]
  chk_erase_to_prog: assert property (s_erase_end |=> state_q == ST_PROGRAM && cnt_q == CNT_W'(PROG_CYCLES - 1))
    else $error("erase phase did not lead to program"); // see [RULE6]
  chk_done_on_end: assert property (s_write_end |=> write_done_flag_q && !wr_q && !write_abort_flag_q)
    else $error("completion not flagged"); // see [RULE9]
  chk_abort_on_reset: assert property (wr_q && core_rst |=> write_abort_flag_q && state_q == ST_IDLE && !wr_q)
    else $error("reset during write not flagged"); // see [RULE10]
  chk_wr_zero_kept: assert property (wr_q && ctrl_wr && !SFR_WDATA_IN[`EE_WR_BIT] && !write_end && !core_rst
    |=> wr_q) else $error("software cleared write bit"); // see [RULE11]
  chk_ctrl_top_zero: assert property ($past(SFR_ADDR_IN) == `EE_CTRL_OFS |-> SFR_RDATA_OUT[7:5] == `EE_CTRL_UNUSED)
    else $error("unimplemented control bits not zero"); // see [RULE15]
  chk_prog_denied: assert property (PROG_MODE_IN && protected_data |=> PROG_DENIED_OUT && PROG_RDATA_OUT == `EE_BYTE_ZERO)
    else $error("protected data reached programmer"); // see [RULE8]
  chk_out_of_space: assert property (wr_q && !addr_in_space(wr_addr_q) |-> !arr_erase && !arr_program)
    else $error("write outside implemented space"); // see [RULE5]

endmodule // eeprom_access_ctrl

`default_nettype wire

// [data_eeprom_access_control_tb.sv]
// Self-checking testbench of the data EEPROM access control block.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

module data_eeprom_access_control_tb;
  import eeprom_pkg::*;

  // ===================================================================
  // Settings and stimulus nets
  // ===================================================================
  // Short write phases keep the run brief; the busy-span check and the program-phase reset timing derive from them.
  localparam int ERA = 8;
  localparam int PRG = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clr_rst = 1'b0;
  logic dog_rst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic cp = 1'b0;
  logic dprot = 1'b1;
  logic pmode = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic prd = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pwdata = 8'h00;
  logic [7:0] prdata;
  logic denied;
  logic busy;
  logic rom_denied;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] v;
  int n;

  // ===================================================================
  // Clock and devices
  // ===================================================================
  // The clock toggles every half period of 10 ns.
  always #5 clk = ~clk;

  // Flash variant under test.
  eeprom_access_ctrl #(.ROM_VARIANT(1'b0), .ERASE_CYCLES(ERA), .PROG_CYCLES(PRG)) u_dut (
    .CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .MASTER_CLEAR_RESET_IN(clr_rst), .WATCHDOG_TIMER_RESET_IN(dog_rst),
    .SFR_ADDR_IN(sfr_addr), .SFR_WR_IN(sfr_wr), .SFR_WDATA_IN(sfr_wdata), .SFR_RDATA_OUT(sfr_rdata),
    .CODE_PROTECT_IN(cp), .DATA_PROTECT_BIT_IN(dprot), .PROG_MODE_IN(pmode), .PROG_ADDR_IN(paddr),
    .PROG_RD_IN(prd), .PROG_WR_IN(pwr), .PROG_WDATA_IN(pwdata), .PROG_RDATA_OUT(prdata),
    .PROG_DENIED_OUT(denied), .WRITE_BUSY_OUT(busy));

  // ROM variant, watched only for its programmer gate.
  eeprom_access_ctrl #(.ROM_VARIANT(1'b1), .ERASE_CYCLES(ERA), .PROG_CYCLES(PRG)) u_rom (
    .CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .MASTER_CLEAR_RESET_IN(clr_rst), .WATCHDOG_TIMER_RESET_IN(dog_rst),
    .SFR_ADDR_IN(sfr_addr), .SFR_WR_IN(sfr_wr), .SFR_WDATA_IN(sfr_wdata), .SFR_RDATA_OUT(),
    .CODE_PROTECT_IN(1'b0), .DATA_PROTECT_BIT_IN(dprot), .PROG_MODE_IN(pmode), .PROG_ADDR_IN(paddr),
    .PROG_RD_IN(prd), .PROG_WR_IN(pwr), .PROG_WDATA_IN(pwdata), .PROG_RDATA_OUT(),
    .PROG_DENIED_OUT(rom_denied), .WRITE_BUSY_OUT());

  // ===================================================================
  // Access tasks
  // ===================================================================
  // Compares a seen value with the expected one and counts the result.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One register write; the strobe stands for exactly one sampling edge.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  // Register read; the answer is registered one edge after the address.
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1;
    d = sfr_rdata;
  endtask

  // Fetch one array byte through the address, control and data registers.
  task automatic ee_read(input logic [7:0] a, output logic [7:0] d);
    reg_wr(`EE_ADDR_OFS, a);
    reg_wr(`EE_CTRL_OFS, 8'h01);
    reg_rd(`EE_DATA_OFS, d);
  endtask

  // Start a byte write by loading data and address, then writing the given value to the control register.
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    reg_wr(`EE_DATA_OFS, d);
    reg_wr(`EE_ADDR_OFS, a);
    reg_wr(`EE_CTRL_OFS, c);
  endtask

  // Counts busy cycles until the write ends; a hang here is a mismatch.
  task automatic wait_idle(output int cnt);
    logic seen;
    seen = 1'b0;
    cnt = 0;
    repeat (200)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b1)
      begin
        seen = 1'b1;
        cnt++;
      end
      else if (seen)
        break;
    end
    check("write_ends", {7'h00, busy}, 8'h00);
  endtask

  // Programmer byte access; read data stands one cycle after the request.
  task automatic prog_acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    paddr <= a;
    pwdata <= d;
    prd <= ~w;
    pwr <= w;
    @(posedge clk);
    prd <= 1'b0;
    pwr <= 1'b0;
    #1;
    q = prdata;
  endtask

  // Pulses one of the synchronous reset sources for a single cycle.
  task automatic pulse_reset(input logic use_dog);
    @(posedge clk);
    clr_rst <= ~use_dog;
    dog_rst <= use_dog;
    @(posedge clk);
    clr_rst <= 1'b0;
    dog_rst <= 1'b0;
  endtask

  // ===================================================================
  // Verdict
  // ===================================================================
  task automatic wrap_up;
    $display("mismatches %0d of %0d comparisons", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog fires after 20000 cycles; the whole sequence needs well under 2000 cycles.
  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end

  // ===================================================================
  // Test sequence
  // ===================================================================
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // Reset state of the control register, aux register and an unmapped place.
    reg_rd(`EE_CTRL_OFS, v); check("ctrl_reset", v, 8'h00);
    reg_rd(`EE_AUX_OFS, v); check("aux_reset", v, 8'h00);
    reg_rd(8'h20, v); check("unmapped", v, 8'h00);
    // Unimplemented control bits ignore writes.
    reg_wr(`EE_CTRL_OFS, 8'hE0);
    reg_rd(`EE_CTRL_OFS, v); check("ctrl_upper", v, 8'h00);
    // Top byte of a fresh array reads erased; the read bit clears itself.
    ee_read(8'h3F, v); check("fresh_byte", v, `EE_BYTE_ERASED);
    reg_rd(`EE_CTRL_OFS, v); check("rd_clears", v, 8'h00);
    // A start without the permit bit is ignored.
    ee_write(8'h3F, 8'h5A, 8'h02);
    reg_rd(`EE_CTRL_OFS, v); check("no_permit", v, 8'h00);
    check("no_permit_busy", {7'h00, busy}, 8'h00);
    // A permitted write runs on the internal timer and sets done only.
    ee_write(8'h3F, 8'h5A, 8'h06);
    wait_idle(n);
    check("busy_span", 8'(n), 8'(ERA + PRG));
    reg_rd(`EE_CTRL_OFS, v); check("done_set", v & 8'h1B, 8'h10);
    ee_read(8'h3F, v); check("written_byte", v, 8'h5A);
    reg_rd(`EE_DATA_OFS, v); check("data_reg", v, 8'h5A);
    // Software clears the done flag.
    reg_wr(`EE_CTRL_OFS, 8'h04);
    reg_rd(`EE_CTRL_OFS, v); check("done_clear", v, 8'h04);
    // Writing zero to the start bit while busy does not stop the write.
    ee_write(8'h00, 8'hA5, 8'h06);
    reg_wr(`EE_CTRL_OFS, 8'h04);
    #1;
    check("wr_zero_busy", {7'h00, busy}, 8'h01);
    reg_rd(`EE_CTRL_OFS, v); check("wr_stays", v & 8'h12, 8'h02);
    wait_idle(n);
    reg_rd(`EE_CTRL_OFS, v); check("wr_cleared", v & 8'h12, 8'h10);
    ee_read(8'h00, v); check("byte_zero", v, 8'hA5);
    // Master clear in the program phase aborts and leaves the byte erased.
    ee_write(8'h10, 8'h33, 8'h06);
    repeat (ERA + 3) @(posedge clk);
    pulse_reset(1'b0);
    // Busy is registered, so it drops one edge after the reset is taken.
    @(posedge clk);
    #1;
    check("clr_busy", {7'h00, busy}, 8'h00);
    reg_rd(`EE_CTRL_OFS, v); check("clr_abort", v, 8'h08);
    ee_read(8'h10, v); check("aborted_byte", v, `EE_BYTE_ERASED);
    // Watchdog in the erase phase aborts as well.
    reg_wr(`EE_CTRL_OFS, 8'h00);
    ee_write(8'h11, 8'h44, 8'h06);
    repeat (2) @(posedge clk);
    pulse_reset(1'b1);
    reg_rd(`EE_CTRL_OFS, v); check("dog_abort", v, 8'h08);
    // A normal completion with the abort flag still set leaves it zero.
    ee_write(8'h11, 8'h44, 8'h0E);
    wait_idle(n);
    reg_rd(`EE_CTRL_OFS, v); check("abort_cleared", v & 8'h18, 8'h10);
    ee_read(8'h11, v); check("rewritten", v, 8'h44);
    // Upper address bits nonzero miss the implemented space.
    ee_write(8'h50, 8'h77, 8'h06);
    wait_idle(n);
    ee_read(8'h50, v); check("out_of_space", v, 8'h00);
    ee_read(8'h10, v); check("alias_untouched", v, `EE_BYTE_ERASED);
    // Code protected: programmer refused, core keeps access.
    cp <= 1'b1;
    pmode <= 1'b1;
    prog_acc(1'b1, 6'h3F, 8'hC3, v);
    prog_acc(1'b0, 6'h3F, 8'h00, v); check("prot_read", v, 8'h00);
    check("prot_denied", {7'h00, denied}, 8'h01);
    ee_read(8'h3F, v); check("core_prot_read", v, 8'h5A);
    // Unprotected: programmer writes and reads back, core sees it.
    cp <= 1'b0;
    prog_acc(1'b1, 6'h01, 8'hC3, v);
    prog_acc(1'b0, 6'h01, 8'h00, v); check("prog_read", v, 8'hC3);
    check("prog_allowed", {7'h00, denied}, 8'h00);
    ee_read(8'h01, v); check("core_sees_prog", v, 8'hC3);
    // The core read uses its own address even while the programmer points elsewhere.
    ee_read(8'h3F, v); check("core_own_addr", v, 8'h5A);
    // ROM variant: configuration bit zero protects, one opens.
    dprot <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rom_protected", {7'h00, rom_denied}, 8'h01);
    dprot <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("rom_open", {7'h00, rom_denied}, 8'h00);
    pmode <= 1'b0;
    wrap_up();
  end

endmodule // data_eeprom_access_control_tb
`default_nettype wire
